// File: rtl/odsa_map.svh
// Register offsets, field positions and reset values of the alert block
`ifndef ODSA_MAP_SVH
`define ODSA_MAP_SVH

// Bus widths
`define ODSA_ADDR_W 12
`define ODSA_DATA_W 32
`define ODSA_VAL_W 24

// Register offsets, one 32-bit register per offset
`define ODSA_ADDR_ALERT_MASK 12'h407
`define ODSA_ADDR_OC_THR 12'h409
`define ODSA_ADDR_CAP_A 12'h40a
`define ODSA_ADDR_CAP_B 12'h40b
`define ODSA_ADDR_CAP_C 12'h40c
`define ODSA_ADDR_CAP_N 12'h40d
`define ODSA_ADDR_FUND_LVL 12'h40f
`define ODSA_ADDR_OC_CFG 12'h418
`define ODSA_ADDR_IRQ_STS 12'h419
`define ODSA_ADDR_IRQ_MASK 12'h41a

// Reset values
`define ODSA_THR_RST 24'hffffff
`define ODSA_FUND_LVL_RST 24'h45d45
`define ODSA_CAP_RST 24'h000000

// Alert mask layout
`define ODSA_DIP_A_BIT 0
`define ODSA_DIP_B_BIT 1
`define ODSA_DIP_C_BIT 2
`define ODSA_SWELL_A_BIT 3
`define ODSA_SWELL_B_BIT 4
`define ODSA_SWELL_C_BIT 5
`define ODSA_ALERT_W 6

// Overcurrent channels: a, b, c, neutral
`define ODSA_OC_A 0
`define ODSA_OC_B 1
`define ODSA_OC_C 2
`define ODSA_OC_N 3
`define ODSA_NCH 4

// Interrupt status layout: alert events low, overcurrent events above
`define ODSA_STS_OC_LSB 6
`define ODSA_STS_W 10

`endif

// File: rtl/odsa_pkg.sv
// Types shared by the alert and overcurrent register block
`include "odsa_map.svh"
package odsa_pkg;

  // Dip and swell levels, packed in the alert mask layout
  typedef struct packed {
    logic [2:0] swell;
    logic [2:0] dip;
  } odsa_cond_t;

  // Half-cycle current rms per channel with its update pulse
  typedef struct packed {
    logic [`ODSA_NCH-1:0] upd;
    logic [`ODSA_NCH-1:0][`ODSA_VAL_W-1:0] rms;
  } odsa_rms_t;

  // Whole state of the register block
  typedef struct packed {
    logic [`ODSA_ALERT_W-1:0] alert_mask;
    logic [`ODSA_VAL_W-1:0] oc_thr;
    logic [`ODSA_NCH-1:0][`ODSA_VAL_W-1:0] cap;
    logic [`ODSA_VAL_W-1:0] fund_lvl;
    logic [`ODSA_NCH-1:0] oc_en;
    logic [`ODSA_STS_W-1:0] irq_sts;
    logic [`ODSA_STS_W-1:0] irq_mask;
    logic [`ODSA_ALERT_W-1:0] cond_q;
    logic [`ODSA_DATA_W-1:0] rdata;
    logic alert_n;
    logic irq;
  } odsa_state_t;

endpackage

// File: rtl/odsa_regs.sv
// Dip/swell alert enables, overcurrent threshold and captures, level constant
`timescale 1ns/100ps
`include "odsa_map.svh"

module odsa_regs
  import odsa_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`ODSA_ADDR_W-1:0] reg_addr,
  input wire logic [`ODSA_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`ODSA_DATA_W-1:0] reg_rdata,
  input wire odsa_cond_t volt_cond,
  input wire odsa_rms_t half_cycle_current_rms,
  input wire logic [`ODSA_NCH-1:0] ext_unused_tie,
  output logic alert_n,
  output logic irq,
  output logic [`ODSA_VAL_W-1:0] fundamental_level_value
);

  odsa_state_t s;
  odsa_state_t next_s;
  logic [`ODSA_NCH-1:0] oc_hit;
  logic [`ODSA_ALERT_W-1:0] cond_now;
  logic [`ODSA_ALERT_W-1:0] cond_rise;
  logic [`ODSA_ALERT_W-1:0] alert_hit;
  logic [`ODSA_NCH-1:0] unused_tie_or;

  // Condition levels in the alert mask layout
  assign cond_now = volt_cond;
  assign cond_rise = cond_now & ~s.cond_q;
  assign unused_tie_or = ext_unused_tie;

  // Enabled dip conditions, phases C, B, A
  assign alert_hit[`ODSA_DIP_C_BIT:`ODSA_DIP_A_BIT] =
    s.alert_mask[`ODSA_DIP_C_BIT:`ODSA_DIP_A_BIT] &
    volt_cond.dip;

  // Enabled swell conditions, phases C, B, A
  assign alert_hit[`ODSA_SWELL_C_BIT:`ODSA_SWELL_A_BIT] =
    s.alert_mask[`ODSA_SWELL_C_BIT:`ODSA_SWELL_A_BIT] &
    volt_cond.swell;

  // Per channel overcurrent detection, unsigned compare
  genvar gi;
  generate
    for (gi = 0; gi < `ODSA_NCH; gi = gi + 1) begin : g_oc
      assign oc_hit[gi] = half_cycle_current_rms.upd[gi] & s.oc_en[gi] &
        (half_cycle_current_rms.rms[gi] > s.oc_thr);
    end
  endgenerate

  // Next state: bus writes, captures, events, read data and pins
  always_comb begin
    next_s = s;
    next_s.rdata = '0;
    next_s.cond_q = cond_now;
    // Register writes; reserved bits are dropped
    if (reg_wr) begin
      case (reg_addr)
        `ODSA_ADDR_ALERT_MASK: begin
          next_s.alert_mask = reg_wdata[`ODSA_ALERT_W-1:0];
        end
        `ODSA_ADDR_OC_THR: begin
          next_s.oc_thr = reg_wdata[`ODSA_VAL_W-1:0];
        end
        `ODSA_ADDR_FUND_LVL: begin
          next_s.fund_lvl = reg_wdata[`ODSA_VAL_W-1:0];
        end
        `ODSA_ADDR_OC_CFG: begin
          next_s.oc_en = reg_wdata[`ODSA_NCH-1:0];
        end
        `ODSA_ADDR_IRQ_STS: begin
          next_s.irq_sts = s.irq_sts & ~reg_wdata[`ODSA_STS_W-1:0];
        end
        `ODSA_ADDR_IRQ_MASK: begin
          next_s.irq_mask = reg_wdata[`ODSA_STS_W-1:0];
        end
        default: begin
          next_s.rdata = '0;
        end
      endcase
    end
    // Captures take the rms on an update above threshold of an enabled channel
    for (int i = 0; i < `ODSA_NCH; i++) begin
      if (oc_hit[i]) begin
        next_s.cap[i] = half_cycle_current_rms.rms[i];
      end
    end
    // Event sets come after the clear so a same-cycle event wins
    next_s.irq_sts[`ODSA_ALERT_W-1:0] =
      next_s.irq_sts[`ODSA_ALERT_W-1:0] | cond_rise;
    next_s.irq_sts[`ODSA_STS_W-1:`ODSA_STS_OC_LSB] =
      next_s.irq_sts[`ODSA_STS_W-1:`ODSA_STS_OC_LSB] | oc_hit;
    // Register reads, data stand one cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `ODSA_ADDR_ALERT_MASK: begin
          next_s.rdata[`ODSA_ALERT_W-1:0] = s.alert_mask;
        end
        `ODSA_ADDR_OC_THR: begin
          next_s.rdata[`ODSA_VAL_W-1:0] = s.oc_thr;
        end
        `ODSA_ADDR_CAP_A: begin
          next_s.rdata[`ODSA_VAL_W-1:0] = s.cap[`ODSA_OC_A];
        end
        `ODSA_ADDR_CAP_B: begin
          next_s.rdata[`ODSA_VAL_W-1:0] = s.cap[`ODSA_OC_B];
        end
        `ODSA_ADDR_CAP_C: begin
          next_s.rdata[`ODSA_VAL_W-1:0] = s.cap[`ODSA_OC_C];
        end
        `ODSA_ADDR_CAP_N: begin
          next_s.rdata[`ODSA_VAL_W-1:0] = s.cap[`ODSA_OC_N];
        end
        `ODSA_ADDR_FUND_LVL: begin
          next_s.rdata[`ODSA_VAL_W-1:0] = s.fund_lvl;
        end
        `ODSA_ADDR_OC_CFG: begin
          next_s.rdata[`ODSA_NCH-1:0] = s.oc_en;
        end
        `ODSA_ADDR_IRQ_STS: begin
          next_s.rdata[`ODSA_STS_W-1:0] = s.irq_sts;
        end
        `ODSA_ADDR_IRQ_MASK: begin
          next_s.rdata[`ODSA_STS_W-1:0] = s.irq_mask;
        end
        default: begin
          next_s.rdata = '0; // Unmapped reads return zero
        end
      endcase
    end
    // Alert pin low while any enabled condition stands
    next_s.alert_n = ~|alert_hit;
    next_s.irq = |(next_s.irq_sts & next_s.irq_mask);
  end

  // State register with documented reset values
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.oc_thr <= `ODSA_THR_RST;
      s.fund_lvl <= `ODSA_FUND_LVL_RST;
      s.cap <= {`ODSA_NCH{`ODSA_CAP_RST}};
      s.alert_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata = s.rdata;
  assign alert_n = s.alert_n;
  assign irq = s.irq;
  assign fundamental_level_value = s.fund_lvl;

  // Checks on the alert pin, one per mask bit
  property p_swell_c;
    @(posedge clk) disable iff (sys_rst)
    s.alert_mask[`ODSA_SWELL_C_BIT] && volt_cond.swell[2]
      |=> !alert_n;
  endproperty
  a_swell_c: assert property (p_swell_c)
    else $error("Phase C swell did not pull alert low");

  property p_swell_b;
    @(posedge clk) disable iff (sys_rst)
    s.alert_mask[`ODSA_SWELL_B_BIT] && volt_cond.swell[1]
      |=> !alert_n;
  endproperty
  a_swell_b: assert property (p_swell_b)
    else $error("Phase B swell did not pull alert low");

  property p_swell_a;
    @(posedge clk) disable iff (sys_rst)
    s.alert_mask[`ODSA_SWELL_A_BIT] && volt_cond.swell[0]
      |=> !alert_n;
  endproperty
  a_swell_a: assert property (p_swell_a)
    else $error("Phase A swell did not pull alert low");

  property p_dip_c;
    @(posedge clk) disable iff (sys_rst)
    s.alert_mask[`ODSA_DIP_C_BIT] && volt_cond.dip[2] |=> !alert_n;
  endproperty
  a_dip_c: assert property (p_dip_c)
    else $error("Phase C dip did not pull alert low");

  property p_dip_b;
    @(posedge clk) disable iff (sys_rst)
    s.alert_mask[`ODSA_DIP_B_BIT] && volt_cond.dip[1] |=> !alert_n;
  endproperty
  a_dip_b: assert property (p_dip_b)
    else $error("Phase B dip did not pull alert low");

  property p_dip_a;
    @(posedge clk) disable iff (sys_rst)
    s.alert_mask[`ODSA_DIP_A_BIT] && volt_cond.dip[0] |=> !alert_n;
  endproperty
  a_dip_a: assert property (p_dip_a)
    else $error("Phase A dip did not pull alert low");

  // Threshold write then read back returns the low field only
  property p_thr_rw;
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == `ODSA_ADDR_OC_THR ##1
      reg_rd && reg_addr == `ODSA_ADDR_OC_THR
      |=> reg_rdata == {8'h00, $past(reg_wdata[`ODSA_VAL_W-1:0], 2)};
  endproperty
  a_thr_rw: assert property (p_thr_rw)
    else $error("Threshold read back differs from write");

  // Captures: update on A and C above threshold, hold on B while off and on N at or below threshold
  property p_cap_a;
    @(posedge clk) disable iff (sys_rst)
    half_cycle_current_rms.upd[`ODSA_OC_A] && s.oc_en[`ODSA_OC_A] &&
      half_cycle_current_rms.rms[`ODSA_OC_A] > s.oc_thr
      |=> s.cap[`ODSA_OC_A] ==
        $past(half_cycle_current_rms.rms[`ODSA_OC_A]);
  endproperty
  a_cap_a: assert property (p_cap_a)
    else $error("Phase A capture not updated");

  property p_cap_b_hold;
    @(posedge clk) disable iff (sys_rst)
    !s.oc_en[`ODSA_OC_B] |=> $stable(s.cap[`ODSA_OC_B]);
  endproperty
  a_cap_b_hold: assert property (p_cap_b_hold)
    else $error("Phase B capture changed while checking is off");

  property p_cap_c;
    @(posedge clk) disable iff (sys_rst)
    half_cycle_current_rms.upd[`ODSA_OC_C] && s.oc_en[`ODSA_OC_C] &&
      half_cycle_current_rms.rms[`ODSA_OC_C] > s.oc_thr
      |=> s.cap[`ODSA_OC_C] ==
        $past(half_cycle_current_rms.rms[`ODSA_OC_C]);
  endproperty
  a_cap_c: assert property (p_cap_c)
    else $error("Phase C capture not updated");

  property p_cap_n_low;
    @(posedge clk) disable iff (sys_rst)
    half_cycle_current_rms.rms[`ODSA_OC_N] <= s.oc_thr
      |=> $stable(s.cap[`ODSA_OC_N]);
  endproperty
  a_cap_n_low: assert property (p_cap_n_low)
    else $error("Neutral capture changed below threshold");

  // Level constant write reaches its output next cycle
  property p_lvl_wr;
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == `ODSA_ADDR_FUND_LVL
      |=> fundamental_level_value == $past(reg_wdata[`ODSA_VAL_W-1:0]);
  endproperty
  a_lvl_wr: assert property (p_lvl_wr)
    else $error("Level constant write lost");

  // No enabled condition for two cycles leaves the pin high
  property p_alert_idle;
    @(posedge clk) disable iff (sys_rst)
    (~|(s.alert_mask & cond_now)) [*2] |=> alert_n;
  endproperty
  a_alert_idle: assert property (p_alert_idle)
    else $error("Alert low with no enabled condition");

  // Interrupt follows unmasked status
  property p_irq;
    @(posedge clk) disable iff (sys_rst)
    |(s.irq_sts & s.irq_mask) |-> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt low with unmasked status set");

  // Remaining captures: update on B and N, hold on A and C
  property p_cap_b;
    @(posedge clk) disable iff (sys_rst)
    half_cycle_current_rms.upd[`ODSA_OC_B] && s.oc_en[`ODSA_OC_B] &&
      half_cycle_current_rms.rms[`ODSA_OC_B] > s.oc_thr
      |=> s.cap[`ODSA_OC_B] ==
        $past(half_cycle_current_rms.rms[`ODSA_OC_B]);
  endproperty
  a_cap_b: assert property (p_cap_b)
    else $error("Phase B capture not updated");

  property p_cap_n;
    @(posedge clk) disable iff (sys_rst)
    half_cycle_current_rms.upd[`ODSA_OC_N] && s.oc_en[`ODSA_OC_N] &&
      half_cycle_current_rms.rms[`ODSA_OC_N] > s.oc_thr
      |=> s.cap[`ODSA_OC_N] ==
        $past(half_cycle_current_rms.rms[`ODSA_OC_N]);
  endproperty
  a_cap_n: assert property (p_cap_n)
    else $error("Neutral capture not updated");

  property p_cap_a_hold;
    @(posedge clk) disable iff (sys_rst)
    !s.oc_en[`ODSA_OC_A] |=> $stable(s.cap[`ODSA_OC_A]);
  endproperty
  a_cap_a_hold: assert property (p_cap_a_hold)
    else $error("Phase A capture changed while checking is off");

  property p_cap_c_hold;
    @(posedge clk) disable iff (sys_rst)
    !s.oc_en[`ODSA_OC_C] |=> $stable(s.cap[`ODSA_OC_C]);
  endproperty
  a_cap_c_hold: assert property (p_cap_c_hold)
    else $error("Phase C capture changed while checking is off");

  // Host writes to a capture place are dropped
  property p_cap_ro;
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == `ODSA_ADDR_CAP_A &&
      !half_cycle_current_rms.upd[`ODSA_OC_A]
      |=> $stable(s.cap[`ODSA_OC_A]);
  endproperty
  a_cap_ro: assert property (p_cap_ro)
    else $error("Phase A capture took a host write");

  // Threshold moves only on its own write
  property p_thr_hold;
    @(posedge clk) disable iff (sys_rst)
    !(reg_wr && reg_addr == `ODSA_ADDR_OC_THR) |=> $stable(s.oc_thr);
  endproperty
  a_thr_hold: assert property (p_thr_hold)
    else $error("Threshold changed without a write");

  // Level constant moves only on its own write
  property p_lvl_hold;
    @(posedge clk) disable iff (sys_rst)
    !(reg_wr && reg_addr == `ODSA_ADDR_FUND_LVL)
      |=> $stable(fundamental_level_value);
  endproperty
  a_lvl_hold: assert property (p_lvl_hold)
    else $error("Level constant changed without a write");

  // Alert mask takes the low six bits of its write
  property p_mask_wr;
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == `ODSA_ADDR_ALERT_MASK
      |=> s.alert_mask == $past(reg_wdata[`ODSA_ALERT_W-1:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr)
    else $error("Alert mask write lost");

  // Read data stand one cycle only, reserved bits zero
  property p_rdata_idle;
    @(posedge clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data left standing");

  property p_reserved;
    @(posedge clk) disable iff (sys_rst)
    reg_rd |=> reg_rdata[`ODSA_DATA_W-1:`ODSA_VAL_W] == '0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved read bits not zero");

  // A condition rise sets its status bit even during a clear
  property p_sts_set;
    @(posedge clk) disable iff (sys_rst)
    |cond_rise |=> (s.irq_sts[`ODSA_ALERT_W-1:0] & $past(cond_rise)) ==
      $past(cond_rise);
  endproperty
  a_sts_set: assert property (p_sts_set)
    else $error("Condition rise lost its status bit");

endmodule

// File: tb/odsa_host.sv
// Host model that reaches the register block over the plain register port
`timescale 1ns/100ps
`include "odsa_map.svh"

module odsa_host
  import odsa_pkg::*;
(
  input wire logic clk,
  output logic [`ODSA_ADDR_W-1:0] reg_addr,
  output logic [`ODSA_DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [`ODSA_DATA_W-1:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // Stale data must not be taken
  endtask

  // One-cycle read strobe; data taken in the following cycle only
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Write then read of one address with no gap between the strobes
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_wdata <= ~d;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
endmodule

// File: tb/tb.sv
// Self-checking bench of the alert and overcurrent register block
`timescale 1ns/100ps
`include "odsa_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  fails++; $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); \
  end end

module tb
  import odsa_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, alert_n, irq;
  logic [23:0] fundamental_level_value;
  odsa_cond_t volt_cond = '0;
  odsa_rms_t rms = '0;
  int fails = 0;
  int check_count = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  odsa_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  odsa_regs u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .volt_cond(volt_cond),
    .half_cycle_current_rms(rms), .ext_unused_tie(4'h0),
    .alert_n(alert_n), .irq(irq),
    .fundamental_level_value(fundamental_level_value));

  // Reset values and read-only places
  task automatic t_reset_and_access();
    u_host.rd(12'h409, d);
    `CHK(d, 32'h00ffffff)
    for (int i = 0; i < 4; i++) begin
      u_host.rd(12'h40a + 12'(i), d);
      `CHK(d, 32'h0)
    end
    u_host.rd(12'h40f, d);
    `CHK(d, 32'h00045d45)
    `CHK(fundamental_level_value, 24'h45d45)
    u_host.rd(12'h407, d);
    `CHK(d, 32'h0)
    `CHK(alert_n, 1'b1)
    u_host.wr_rd(12'h409, 32'hffffffff, d);
    `CHK(d, 32'h00ffffff)
    u_host.wr_rd(12'h409, 32'ha5123456, d);
    `CHK(d, 32'h00123456)
    u_host.wr(12'h40a, 32'h00abcdef);
    u_host.rd(12'h40a, d);
    `CHK(d, 32'h0)
    u_host.wr(12'h40e, 32'h12345678);
    u_host.rd(12'h40e, d);
    `CHK(d, 32'h0)
    u_host.wr(12'h40f, 32'hff123456);
    u_host.rd(12'h40f, d);
    `CHK(d, 32'h00123456)
    `CHK(fundamental_level_value, 24'h123456)
  endtask

  // Each enable bit pairs with its own dip or swell condition only
  task automatic t_alert();
    for (int i = 0; i < 6; i++) begin
      u_host.wr(12'h407, 32'h1 << i);
      @(posedge clk) volt_cond <= 6'h3f ^ (6'h1 << i);
      repeat (2) @(posedge clk);
      #1 `CHK(alert_n, 1'b1)
      @(posedge clk) volt_cond <= 6'h1 << i;
      repeat (2) @(posedge clk);
      #1 `CHK(alert_n, 1'b0)
      @(posedge clk) volt_cond <= '0;
      repeat (2) @(posedge clk);
      #1 `CHK(alert_n, 1'b1)
    end
    u_host.rd(12'h407, d);
    `CHK(d, 32'h20)
    u_host.wr(12'h407, 32'hffffffff);
    u_host.rd(12'h407, d);
    `CHK(d, 32'h3f)
  endtask

  // Single update pulse on one channel
  task automatic pulse(input int ch, input logic [23:0] v);
    @(posedge clk);
    rms.rms[ch] <= v;
    rms.upd <= 4'(1 << ch);
    @(posedge clk);
    rms.upd <= '0;
  endtask

  // Strict greater-than capture, gated by each channel's enable
  task automatic t_capture();
    u_host.wr(12'h409, 32'h00000100);
    u_host.wr(12'h418, 32'h0000000f);
    for (int i = 0; i < 4; i++) begin
      pulse(i, 24'h000100);
      u_host.rd(12'h40a + 12'(i), d);
      `CHK(d, 32'h0)
      pulse(i, 24'h000101 + 24'(i));
      u_host.rd(12'h40a + 12'(i), d);
      `CHK(d, 32'h101 + i)
    end
    u_host.wr(12'h418, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      pulse(i, 24'hfffffe);
      u_host.rd(12'h40a + 12'(i), d);
      `CHK(d, 32'h101 + i)
    end
  endtask

  // Sticky status, mask and write-one-to-clear
  task automatic t_irq();
    u_host.rd(12'h419, d);
    `CHK(d, 32'h3ff)
    `CHK(irq, 1'b0)
    u_host.wr(12'h41a, 32'h00000200);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b1)
    u_host.wr(12'h419, 32'h000001ff);
    u_host.rd(12'h419, d);
    `CHK(d, 32'h200)
    u_host.wr(12'h419, 32'h00000200);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b0)
    u_host.rd(12'h419, d);
    `CHK(d, 32'h0)
  endtask

  // Verdict and end of run
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_and_access();
    t_alert();
    t_capture();
    t_irq();
    give_verdict();
  end

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
endmodule
